// ===== rtl/rss_pkg.sv
// Package for the run, stop and sleep supervisor: register map, fields, resets and timing
`default_nettype none

package rss_pkg;

    // Register byte addresses
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STOP_THRESH = 5'h04;
    localparam logic [4:0] ADDR_STOP_TIME = 5'h08;
    localparam logic [4:0] ADDR_WAKE_DELAY = 5'h0C;
    localparam logic [4:0] ADDR_FLOOR = 5'h10;
    localparam logic [4:0] ADDR_STATUS = 5'h14;
    localparam logic [4:0] ADDR_FREQ_OUT = 5'h18;

    // Frequencies in 0.01 Hz, stop time in 0.01 s, wake delay in 0.1 s
    localparam logic [15:0] STOP_THRESH_RST = 16'h0032;
    localparam logic [15:0] STOP_THRESH_MAX = 16'h2710;
    localparam logic [15:0] STOP_TIME_RST = 16'h0032;
    localparam logic [15:0] STOP_TIME_MAX = 16'h2710;
    localparam logic [15:0] WAKE_DELAY_RST = 16'h0000;
    localparam logic [15:0] WAKE_DELAY_MAX = 16'h8CA0;
    localparam logic [15:0] FLOOR_RST = 16'h0000;

    // Below-floor action codes
    localparam logic [1:0] ACT_RUN_AT_FLOOR = 2'h0;
    localparam logic [1:0] ACT_STOP = 2'h1;
    localparam logic [1:0] ACT_SLEEP = 2'h2;

    // Timing: one base tick of 10 ms at a 40 MHz clock
    localparam int CLK_HZ = 40000000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam logic [3:0] TICKS_PER_WAKE_UNIT = 4'hA;

    // Control register layout, low bits of the word
    typedef struct packed {
        logic svc_mode;
        logic [1:0] below_floor_action;
        logic power_on_terminal_guard;
        logic stop_detect_source;
    } rss_ctrl_t;

    localparam rss_ctrl_t CTRL_RST = '{svc_mode: 1'b1, below_floor_action: 2'h0,
        power_on_terminal_guard: 1'b0, stop_detect_source: 1'b0};

    // Supervisor states
    typedef enum logic [4:0] {
        ST_INIT = 5'h01,
        ST_GUARD = 5'h02,
        ST_STOP = 5'h04,
        ST_RUN = 5'h08,
        ST_SLEEP = 5'h10
    } rss_state_t;

endpackage : rss_pkg

`default_nettype wire

// ===== rtl/rss_supervisor.sv
// Run, stop and sleep supervisor with an Avalon-MM register slave
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`default_nettype none

module rss_supervisor #(
    parameter int TICK_CYCLES = rss_pkg::TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic cmd_from_terminal,
    input wire logic run_cmd,
    input wire logic [15:0] setpoint,
    input wire logic [15:0] feedback_speed,
    output logic running,
    output logic coasting,
    output logic sleeping,
    output logic guard_lock,
    output logic motor_stopped,
    output logic [15:0] freq_out
);

    // Clamp a written value to its documented upper bound
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] mx);
        clamp16 = (v > mx) ? mx : v;
    endfunction : clamp16

    rss_pkg::rss_ctrl_t ctrl_q;
    logic [15:0] stop_thresh_q;
    logic [15:0] stop_time_q;
    logic [15:0] wake_delay_q;
    logic [15:0] floor_q;
    logic waitreq_q;
    logic [31:0] rdata_q;
    rss_pkg::rss_state_t state_q;
    rss_pkg::rss_state_t state_d;
    logic [31:0] tick_cnt_q;
    logic tick_q;
    logic [3:0] wake_pre_q;
    logic [15:0] wake_cnt_q;
    logic [15:0] stop_cnt_q;
    logic stopped_q;
    logic [15:0] freq_q;
    logic [15:0] freq_d;
    logic bus_req;
    logic bus_take;
    logic below_floor;
    logic [15:0] sel_speed;
    logic wake_done;
    logic [31:0] rd_mux;

    assign bus_req = avs_read | avs_write;
    assign bus_take = bus_req & ~waitreq_q;
    assign below_floor = (floor_q != 16'h0000) && (setpoint < floor_q);

    // Wait one cycle on every request, then release for exactly one edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            waitreq_q <= 1'b1;
        end else if (bus_req && waitreq_q) begin
            waitreq_q <= 1'b0;
        end else begin
            waitreq_q <= 1'b1;
        end
    end

    // Register writes at the releasing edge; ranges clamp, byteenable bit 0 alone gates the write of bits 15:0
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctrl_q <= rss_pkg::CTRL_RST;
            stop_thresh_q <= rss_pkg::STOP_THRESH_RST;
            stop_time_q <= rss_pkg::STOP_TIME_RST;
            wake_delay_q <= rss_pkg::WAKE_DELAY_RST;
            floor_q <= rss_pkg::FLOOR_RST;
        end else if (bus_take && avs_write && avs_byteenable[0]) begin
            case (avs_address)
                rss_pkg::ADDR_CTRL: begin
                    ctrl_q <= avs_writedata[$bits(rss_pkg::rss_ctrl_t)-1:0];
                end
                rss_pkg::ADDR_STOP_THRESH: begin
                    stop_thresh_q <= clamp16(avs_writedata[15:0], rss_pkg::STOP_THRESH_MAX);
                end
                rss_pkg::ADDR_STOP_TIME: begin
                    stop_time_q <= clamp16(avs_writedata[15:0], rss_pkg::STOP_TIME_MAX);
                end
                rss_pkg::ADDR_WAKE_DELAY: begin
                    wake_delay_q <= clamp16(avs_writedata[15:0], rss_pkg::WAKE_DELAY_MAX);
                end
                rss_pkg::ADDR_FLOOR: begin
                    floor_q <= avs_writedata[15:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            rss_pkg::ADDR_CTRL: rd_mux = {27'h0, ctrl_q};
            rss_pkg::ADDR_STOP_THRESH: rd_mux = {16'h0, stop_thresh_q};
            rss_pkg::ADDR_STOP_TIME: rd_mux = {16'h0, stop_time_q};
            rss_pkg::ADDR_WAKE_DELAY: rd_mux = {16'h0, wake_delay_q};
            rss_pkg::ADDR_FLOOR: rd_mux = {16'h0, floor_q};
            rss_pkg::ADDR_STATUS: rd_mux = {26'h0, state_q, stopped_q};
            rss_pkg::ADDR_FREQ_OUT: rd_mux = {16'h0, freq_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data registered so it stands at the releasing edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (bus_req && waitreq_q && avs_read) begin
            rdata_q <= rd_mux;
        end
    end

    // Base 10 ms tick
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= 32'h0000_0000;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            tick_q <= 1'b0;
        end
    end

    // Speed under test: commanded only when selected and in vector mode
    assign sel_speed = (!ctrl_q.stop_detect_source && ctrl_q.svc_mode) ? freq_q : feedback_speed;

    // Stop detection: continuous time under threshold, any excursion restarts
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stop_cnt_q <= 16'h0000;
            stopped_q <= 1'b0;
        end else if (sel_speed >= stop_thresh_q) begin
            stop_cnt_q <= 16'h0000;
            stopped_q <= 1'b0;
        end else begin
            if (stop_cnt_q >= stop_time_q) begin
                stopped_q <= 1'b1;
            end else if (tick_q) begin
                stop_cnt_q <= stop_cnt_q + 16'h0001;
            end
        end
    end

    // Wake timer in 0.1 s units while sleeping with setpoint above the floor
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wake_pre_q <= 4'h0;
            wake_cnt_q <= 16'h0000;
        end else if (state_q != rss_pkg::ST_SLEEP || below_floor) begin
            wake_pre_q <= 4'h0;
            wake_cnt_q <= 16'h0000;
        end else if (tick_q && !wake_done) begin
            if (wake_pre_q == rss_pkg::TICKS_PER_WAKE_UNIT - 4'h1) begin
                wake_pre_q <= 4'h0;
                wake_cnt_q <= wake_cnt_q + 16'h0001;
            end else begin
                wake_pre_q <= wake_pre_q + 4'h1;
            end
        end
    end

    assign wake_done = (wake_cnt_q >= wake_delay_q);

    // Supervisor state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            rss_pkg::ST_INIT: begin
                if (cmd_from_terminal && run_cmd) begin
                    state_d = ctrl_q.power_on_terminal_guard ? rss_pkg::ST_RUN
                                                             : rss_pkg::ST_GUARD;
                end else begin
                    state_d = rss_pkg::ST_STOP;
                end
            end
            rss_pkg::ST_GUARD: begin
                if (!run_cmd || !cmd_from_terminal) begin
                    state_d = rss_pkg::ST_STOP;
                end
            end
            rss_pkg::ST_STOP: begin
                if (run_cmd) begin
                    state_d = rss_pkg::ST_RUN;
                end
            end
            rss_pkg::ST_RUN: begin
                if (!run_cmd) begin
                    state_d = rss_pkg::ST_STOP;
                end else if (below_floor && ctrl_q.below_floor_action == rss_pkg::ACT_SLEEP) begin
                    state_d = rss_pkg::ST_SLEEP;
                end
            end
            rss_pkg::ST_SLEEP: begin
                if (!run_cmd) begin
                    state_d = rss_pkg::ST_STOP;
                end else if (ctrl_q.below_floor_action != rss_pkg::ACT_SLEEP) begin
                    state_d = rss_pkg::ST_RUN;
                end else if (!below_floor && wake_done) begin
                    state_d = rss_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = rss_pkg::ST_STOP;
            end
        endcase
    end

    // State register; reset stands for power-on, INIT is the initialisation cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= rss_pkg::ST_INIT;
        end else begin
            state_q <= state_d;
        end
    end

    // Frequency command chosen by the below-floor action
    always_comb begin
        freq_d = 16'h0000;
        if (state_d == rss_pkg::ST_RUN) begin
            if (!below_floor) begin
                freq_d = setpoint;
            end else if (ctrl_q.below_floor_action == rss_pkg::ACT_RUN_AT_FLOOR) begin
                freq_d = floor_q;
            end else begin
                freq_d = 16'h0000;
            end
        end
    end

    // Output registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            freq_q <= 16'h0000;
            running <= 1'b0;
            coasting <= 1'b0;
            sleeping <= 1'b0;
            guard_lock <= 1'b0;
        end else begin
            freq_q <= freq_d;
            running <= (state_d == rss_pkg::ST_RUN) && (freq_d != 16'h0000);
            coasting <= (state_d == rss_pkg::ST_SLEEP);
            sleeping <= (state_d == rss_pkg::ST_SLEEP);
            guard_lock <= (state_d == rss_pkg::ST_GUARD);
        end
    end

    assign avs_waitrequest = waitreq_q;
    assign avs_readdata = rdata_q;
    assign motor_stopped = stopped_q;
    assign freq_out = freq_q;

endmodule : rss_supervisor

`default_nettype wire

// ===== sim/rss_supervisor_assertions.sv
// Port checker for the run, stop and sleep supervisor
`default_nettype none
module rss_supervisor_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic run_cmd,
    input wire logic running,
    input wire logic coasting,
    input wire logic sleeping,
    input wire logic guard_lock,
    input wire logic [15:0] freq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Steps of leaving or keeping the power-on lock
    sequence s_locked_drop;
        guard_lock && !run_cmd;
    endsequence
    sequence s_locked_held;
        guard_lock && run_cmd;
    endsequence
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer missing");
    a_bus_low_once: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer too long");
    a_bus_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("bus answer without request");
    a_sleep_coasts: assert property (sleeping |-> coasting && !running && freq_out == 16'h0000)
        else $error("sleep not coasting");
    a_lock_idle: assert property (guard_lock |-> !running)
        else $error("running while locked");
    a_lock_free: assert property (s_locked_drop |=> !guard_lock)
        else $error("lock kept after drop");
    a_lock_kept: assert property (s_locked_held |=> guard_lock)
        else $error("lock lost with command held");
    a_drop_stops: assert property (!run_cmd |=> !running)
        else $error("running without command");
    a_run_drives: assert property (running |-> freq_out != 16'h0000)
        else $error("running at zero");
    a_reset_quiet: assert property ($past(reset) |-> avs_waitrequest && !running && !guard_lock)
        else $error("outputs busy after reset");
endmodule : rss_supervisor_checker

bind rss_supervisor rss_supervisor_checker i_chk (.clk_sys, .reset, .avs_read, .avs_write,
    .avs_waitrequest, .run_cmd, .running, .coasting, .sleeping, .guard_lock, .freq_out);
`default_nettype wire

// ===== sim/rss_source.sv
// Model of the run terminals and the setpoint and speed sources
`default_nettype none
module rss_source (
    input wire logic clk_sys,
    input wire logic want_run,
    input wire logic want_term,
    input wire logic [15:0] want_set,
    input wire logic [15:0] want_fb,
    output logic run_cmd,
    output logic cmd_from_terminal,
    output logic [15:0] setpoint,
    output logic [15:0] feedback_speed
);
    timeunit 1ns;
    timeprecision 1ps;
    // Lines change just after the edge and hold for the cycle
    always_ff @(posedge clk_sys) begin
        run_cmd <= want_run;
        cmd_from_terminal <= want_term;
        setpoint <= want_set;
        feedback_speed <= want_fb;
    end
endmodule : rss_source
`default_nettype wire

// ===== sim/rss_supervisor_bench.sv
// Self-checking bench for the run, stop and sleep supervisor
`default_nettype none
module rss_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [4:0] adr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic want_run = 1'b1;
    logic want_term = 1'b1;
    logic [15:0] want_set = 16'h1388;
    logic [15:0] want_fb = 16'h0000;
    logic [31:0] avs_readdata, q;
    logic avs_waitrequest, run_cmd, cmd_from_terminal, running, coasting, sleeping, guard_lock, motor_stopped;
    logic [15:0] setpoint, feedback_speed, freq_out, sp;
    logic [31:0] lfsr = 32'h42788EAC;
    logic [31:0] stop_ctrl [4] = '{32'h10, 32'h11, 32'h11, 32'h00};
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int cnt;

    rss_source i_src (.clk_sys, .want_run, .want_term, .want_set, .want_fb, .run_cmd, .cmd_from_terminal,
        .setpoint, .feedback_speed);
    rss_supervisor #(.TICK_CYCLES(4)) i_dut (.clk_sys, .reset, .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
        .cmd_from_terminal, .run_cmd, .setpoint, .feedback_speed, .running, .coasting, .sleeping,
        .guard_lock, .motor_stopped, .freq_out);

    // Random source and expectations
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr_next
    function automatic logic [31:0] rst_val(input int i);
        return (i == 0) ? 32'h10 : ((i == 1 || i == 2) ? 32'h32 : 32'h0);
    endfunction : rst_val
    function automatic logic [15:0] below_freq(input int act);
        return (act == 0) ? 16'h03E8 : 16'h0000;
    endfunction : below_freq

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // One bus transfer, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic conclude();
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Cycle ceiling against a hang
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        sp = 16'h1388;
        cyc(8);
        reset <= 1'b0;
        cyc(6);
        chk("guard_lock", 1, guard_lock);
        chk("running", 0, running);
        want_run <= 1'b0;
        cyc(5);
        chk("guard_lock", 0, guard_lock);
        want_run <= 1'b1;
        cyc(5);
        chk("freq_out", sp, freq_out);
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 5'(i * 4), 32'h0);
            if (i < 5 || i == 7) chk("reset value", rst_val(i), q);
            else chk("live register", (i == 5) ? {26'h0, rss_pkg::ST_RUN, 1'b0} : {16'h0, sp}, q);
        end
        bus(1'b1, rss_pkg::ADDR_STOP_THRESH, 32'hFFFF);
        bus(1'b0, rss_pkg::ADDR_STOP_THRESH, 32'h0);
        chk("threshold clamp", 32'h2710, q);
        bus(1'b1, rss_pkg::ADDR_WAKE_DELAY, 32'hFFFF);
        bus(1'b0, rss_pkg::ADDR_WAKE_DELAY, 32'h0);
        chk("wake clamp", 32'h8CA0, q);
        bus(1'b1, rss_pkg::ADDR_WAKE_DELAY, 32'h0);
        bus(1'b1, rss_pkg::ADDR_FLOOR, 32'h3E8);
        for (int a = 0; a < 3; a++) begin
            bus(1'b1, rss_pkg::ADDR_CTRL, 32'(32'h10 | (a << 2)));
            lfsr = lfsr_next(lfsr);
            want_set <= 16'(lfsr % 900) + 16'h0032;
            cyc(5);
            chk("freq_out", below_freq(a), freq_out);
            chk("sleeping", a == 2, sleeping);
            chk("coasting", a == 2, coasting);
            sp = 16'(lfsr % 5000) + 16'h03E8;
            want_set <= sp;
            cyc(5);
            chk("freq_out", sp, freq_out);
        end
        // Wake delay of 0.1 s with a dip that must restart it
        bus(1'b1, rss_pkg::ADDR_WAKE_DELAY, 32'h1);
        want_set <= 16'h0064;
        cyc(5);
        want_set <= sp;
        cyc(20);
        want_set <= 16'h0064;
        cyc(2);
        want_set <= sp;
        cnt = 0;
        while (running !== 1'b1 && cnt < 200) begin
            @(posedge clk_sys);
            cnt++;
        end
        chk("wake cycles", 1, cnt >= 38 && cnt <= 50);
        // Stop detection on each speed source
        bus(1'b1, rss_pkg::ADDR_STOP_THRESH, 32'h64);
        bus(1'b1, rss_pkg::ADDR_STOP_TIME, 32'h2);
        want_run <= 1'b0;
        cyc(4);
        chk("early stop", 0, motor_stopped);
        for (int k = 0; k < 4; k++) begin
            lfsr = lfsr_next(lfsr);
            bus(1'b1, rss_pkg::ADDR_CTRL, stop_ctrl[k]);
            want_fb <= (k == 2) ? 16'h0000 : 16'(lfsr % 9000) + 16'h00C8;
            cyc(30);
            chk("motor_stopped", k != 1 && k != 3, motor_stopped);
        end
        // Second power-on with the command from another channel: no lock, runs at once
        want_run <= 1'b1;
        want_term <= 1'b0;
        reset <= 1'b1;
        cyc(3);
        reset <= 1'b0;
        cyc(6);
        chk("guard_lock", 0, guard_lock);
        chk("freq_out", sp, freq_out);
        conclude();
    end
endmodule : rss_supervisor_bench
`default_nettype wire
